// file: include/bla_pkg.sv
// Shared constants and types for the byte lane and alignment block.
// Assumes a 32-bit data path, a 100 MHz mclk and synchronous active-low reset.
package bla_pkg;
   localparam int          DATA_W       = 32;
   localparam int          PC_W         = 30;
   localparam int          REG_AW       = 8;
   // Register byte addresses.
   localparam logic [7:0]  REG_CFG      = 8'h00;
   localparam logic [7:0]  REG_CPS      = 8'h04;
   localparam logic [7:0]  REG_ALU      = 8'h08;
   localparam logic [7:0]  REG_STAT     = 8'h0C;
   localparam logic [7:0]  REG_PC       = 8'h10;
   // Field positions.
   localparam int          CFG_BO_BIT   = 0;
   localparam int          CFG_DW_BIT   = 1;
   localparam int          CPS_TU_BIT   = 0;
   localparam int          CPS_FZ_BIT   = 1;
   localparam int          ALU_BP_LSB   = 0;
   localparam int          STAT_CNT_LSB = 0;
   localparam int          CNT_W        = 16;
   // Access option codes.
   localparam logic [2:0]  OPT_WORD     = 3'h0;
   localparam logic [2:0]  OPT_BYTE     = 3'h1;
   localparam logic [2:0]  OPT_HALF     = 3'h2;
   localparam logic [1:0]  LOW_ALIGNED  = 2'h0;
   localparam logic [1:0]  BP_RESET     = 2'h0;

   typedef enum logic [1:0] {BLA_SP_MEM, BLA_SP_IO, BLA_SP_COP, BLA_SP_ROM} bla_space_t;
   typedef enum logic [1:0] {BLA_SZ_WORD, BLA_SZ_BYTE, BLA_SZ_HALF, BLA_SZ_OTHER} bla_size_t;
   typedef enum logic [1:0] {BLA_EX_BYTE, BLA_EX_HALF, BLA_EX_HALF_S, BLA_EX_NONE} bla_ext_t;

   // Data length named by an access option code.
   function automatic bla_size_t bla_opt_size(input logic [2:0] access_option_field);
      unique case (access_option_field)
         OPT_WORD: return BLA_SZ_WORD;
         OPT_BYTE: return BLA_SZ_BYTE;
         OPT_HALF: return BLA_SZ_HALF;
         default:  return BLA_SZ_OTHER;
      endcase
   endfunction
endpackage

// file: include/bla_if.sv
// Carriers between the top of the lane block and its two helpers.
// Assumes both ends sit in the mclk domain; all signals are combinational.
`timescale 1ns/10ps
interface bla_lane_if;
   logic [31:0]        word;
   logic [31:0]        src;
   logic [1:0]         lane;
   logic               bo;
   bla_pkg::bla_size_t size;
   logic               sign;
   logic [31:0]        ld_out;
   logic [31:0]        st_out;
   modport sel  (input word, src, lane, bo, size, sign, output ld_out, st_out);
   modport user (output word, src, lane, bo, size, sign, input ld_out, st_out);
endinterface

interface bla_chk_if;
   logic [1:0]          addr_lo;
   logic [2:0]          access_option_field;
   bla_pkg::bla_space_t space;
   logic                tu;
   logic                trap;
   modport chk  (input addr_lo, access_option_field, space, tu, output trap);
   modport user (output addr_lo, access_option_field, space, tu, input trap);
endinterface

// file: logic/bla_lane_sel.sv
// Byte and half-word lane extraction for loads and replication for stores.
// Assumes the caller supplies the lane code and byte order; purely combinational.
`timescale 1ns/10ps
module bla_lane_sel (
   bla_lane_if.sel l
);
   logic [1:0]  byte_idx;
   logic        half_hi;
   logic [7:0]  byte_val;
   logic [15:0] half_val;

   always_comb begin
      byte_idx = l.bo ? l.lane : ~l.lane;
      half_hi  = l.bo ? l.lane[1] : ~l.lane[1];
      byte_val = l.word[byte_idx*8 +: 8];
      half_val = half_hi ? l.word[31:16] : l.word[15:0];
      unique case (l.size)
         bla_pkg::BLA_SZ_BYTE: begin
            l.ld_out = {{24{l.sign & byte_val[7]}}, byte_val};
            l.st_out = {4{l.src[7:0]}};
         end
         bla_pkg::BLA_SZ_HALF: begin
            l.ld_out = {{16{l.sign & half_val[15]}}, half_val};
            l.st_out = {2{l.src[15:0]}};
         end
         default: begin
            l.ld_out = l.word;
            l.st_out = l.src;
         end
      endcase
   end
endmodule

// file: logic/bla_align_chk.sv
// Unaligned access detector for memory loads and stores.
// Assumes the option code and address bits belong to the access being issued.
`timescale 1ns/10ps
module bla_align_chk (
   bla_chk_if.chk c
);
   bla_pkg::bla_size_t size;

   always_comb begin
      size = bla_pkg::bla_opt_size(c.access_option_field);
      c.trap = 1'b0;
      // I/O and coprocessor traffic is never checked.
      if (c.tu && c.space == bla_pkg::BLA_SP_MEM) begin
         unique case (size)
            bla_pkg::BLA_SZ_WORD: c.trap = (c.addr_lo != bla_pkg::LOW_ALIGNED);
            bla_pkg::BLA_SZ_HALF: c.trap = c.addr_lo[0];
            default:              c.trap = 1'b0;
         endcase
      end
   end
endmodule

// file: logic/bla_top.sv
// Byte lane selection, alignment trap and fetch addressing for the external access path.
// Assumes one outstanding bus read at a time and a bus that answers every read.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
module bla_top (
   input  wire logic                mclk,
   input  wire logic                rstn,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   input  wire logic                acc_req,
   output logic                     acc_ready,
   input  wire logic [31:0]         acc_addr,
   input  wire logic [2:0]          acc_opt,
   input  wire bla_pkg::bla_space_t acc_space,
   input  wire logic                acc_load,
   input  wire logic                acc_sign,
   input  wire logic [31:0]         acc_src,
   output logic      [31:0]         ld_data,
   output logic                     ld_valid,
   input  wire logic                fetch_req,
   output logic                     fetch_ready,
   input  wire logic                jump_req,
   input  wire logic [31:0]         jump_addr,
   output logic      [31:0]         ins_word,
   output logic                     ins_valid,
   output logic                     bus_req,
   output logic      [31:0]         bus_addr,
   output logic      [2:0]          bus_opt,
   output bla_pkg::bla_space_t      bus_space,
   output logic                     bus_instr,
   output logic                     bus_wr,
   output logic      [31:0]         bus_wdata,
   input  wire logic [31:0]         bus_rdata,
   input  wire logic                bus_rvalid,
   input  wire logic                ext_req,
   input  wire bla_pkg::bla_ext_t   ext_op,
   input  wire logic [31:0]         ext_word,
   output logic      [31:0]         ext_result,
   output logic                     ext_valid,
   output logic                     trap_unaligned
);
   typedef enum logic [1:0] {BLA_IDLE, BLA_WAIT_DATA, BLA_WAIT_INS} bla_st_t;

   typedef struct packed {
      bla_st_t             st;
      logic                bo;
      logic                dw;
      logic                tu;
      logic                fz;
      logic [1:0]          bp;
      logic [29:0]         pc;
      logic [1:0]          ld_lane;
      bla_pkg::bla_size_t  ld_size;
      logic                ld_sign;
      logic                bus_req;
      logic [31:0]         bus_addr;
      logic [2:0]          bus_opt;
      bla_pkg::bla_space_t bus_space;
      logic                bus_instr;
      logic                bus_wr;
      logic [31:0]         bus_wdata;
      logic [31:0]         ld_data;
      logic                ld_valid;
      logic [31:0]         ins_word;
      logic                ins_valid;
      logic [31:0]         ext_result;
      logic                ext_valid;
      logic                trap;
      logic [15:0]         trap_cnt;
      logic [31:0]         rdata;
   } bla_state_t;

   localparam bla_state_t RESET_STATE = '{
      st: BLA_IDLE,
      bo: 1'b0,
      dw: 1'b0,
      tu: 1'b0,
      fz: 1'b0,
      bp: bla_pkg::BP_RESET,
      pc: '0,
      ld_lane: '0,
      ld_size: bla_pkg::BLA_SZ_WORD,
      ld_sign: 1'b0,
      bus_req: 1'b0,
      bus_addr: '0,
      bus_opt: bla_pkg::OPT_WORD,
      bus_space: bla_pkg::BLA_SP_MEM,
      bus_instr: 1'b0,
      bus_wr: 1'b0,
      bus_wdata: '0,
      ld_data: '0,
      ld_valid: 1'b0,
      ins_word: '0,
      ins_valid: 1'b0,
      ext_result: '0,
      ext_valid: 1'b0,
      trap: 1'b0,
      trap_cnt: '0,
      rdata: '0
   };

   bla_state_t s_reg;
   bla_state_t s_next;

   bla_lane_if ld_if ();
   bla_lane_if st_if ();
   bla_lane_if ex_if ();
   bla_chk_if  chk_if ();

   bla_lane_sel u_ld_sel (.l(ld_if));
   bla_lane_sel u_st_sel (.l(st_if));
   bla_lane_sel u_ex_sel (.l(ex_if));
   bla_align_chk u_chk (.c(chk_if));

   // Hardware lane handling applies only with width enable set and off the
   // coprocessor path; coprocessor words always pass untouched.
   function automatic logic hw_lanes(input logic dw, input bla_pkg::bla_space_t sp);
      return dw && sp != bla_pkg::BLA_SP_COP;
   endfunction

   logic                acc_go;
   logic                fetch_go;
   logic                acc_hw;
   bla_pkg::bla_size_t  acc_size;

   always_comb begin
      acc_size = bla_pkg::bla_opt_size(acc_opt);
      acc_hw   = hw_lanes(s_reg.dw, acc_space);
      acc_go   = acc_req && s_reg.st == BLA_IDLE;
      // Data accesses take priority; the fetch stream waits until acc_req drops and the block is back in BLA_IDLE.
      fetch_go = fetch_req && !acc_req && s_reg.st == BLA_IDLE;
   end

   always_comb begin
      chk_if.addr_lo = acc_addr[1:0];
      chk_if.access_option_field     = acc_opt;
      chk_if.space   = acc_space;
      chk_if.tu      = s_reg.tu;

      st_if.word = '0;
      st_if.src  = acc_src;
      st_if.lane = acc_addr[1:0];
      st_if.bo   = s_reg.bo;
      st_if.size = acc_hw ? acc_size : bla_pkg::BLA_SZ_WORD;
      st_if.sign = 1'b0;

      ld_if.word = bus_rdata;
      ld_if.src  = '0;
      ld_if.lane = s_reg.ld_lane;
      ld_if.bo   = s_reg.bo;
      ld_if.size = s_reg.ld_size;
      ld_if.sign = s_reg.ld_sign;

      ex_if.word = ext_word;
      ex_if.src  = '0;
      ex_if.lane = s_reg.bp;
      ex_if.bo   = s_reg.bo;
      ex_if.sign = ext_op == bla_pkg::BLA_EX_HALF_S;
      unique case (ext_op)
         bla_pkg::BLA_EX_BYTE:   ex_if.size = bla_pkg::BLA_SZ_BYTE;
         bla_pkg::BLA_EX_HALF,
         bla_pkg::BLA_EX_HALF_S: ex_if.size = bla_pkg::BLA_SZ_HALF;
         default:                ex_if.size = bla_pkg::BLA_SZ_WORD;
      endcase
   end

   always_comb begin
      s_next           = s_reg;
      s_next.bus_req   = 1'b0;
      s_next.ld_valid  = 1'b0;
      s_next.ins_valid = 1'b0;
      s_next.ext_valid = 1'b0;
      s_next.trap      = 1'b0;
      s_next.rdata     = '0;

      if (reg_wr) begin
         unique case (reg_addr)
            bla_pkg::REG_CFG: begin
               s_next.bo = reg_wdata[bla_pkg::CFG_BO_BIT];
               s_next.dw = reg_wdata[bla_pkg::CFG_DW_BIT];
            end
            bla_pkg::REG_CPS: begin
               s_next.tu = reg_wdata[bla_pkg::CPS_TU_BIT];
               s_next.fz = reg_wdata[bla_pkg::CPS_FZ_BIT];
            end
            bla_pkg::REG_ALU: begin
               s_next.bp = reg_wdata[bla_pkg::ALU_BP_LSB +: 2];
            end
            bla_pkg::REG_STAT: begin
               // Any write clears the trap count.
               s_next.trap_cnt = '0;
            end
            default: ;
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            bla_pkg::REG_CFG: begin
               s_next.rdata[bla_pkg::CFG_BO_BIT] = s_reg.bo;
               s_next.rdata[bla_pkg::CFG_DW_BIT] = s_reg.dw;
            end
            bla_pkg::REG_CPS: begin
               s_next.rdata[bla_pkg::CPS_TU_BIT] = s_reg.tu;
               s_next.rdata[bla_pkg::CPS_FZ_BIT] = s_reg.fz;
            end
            bla_pkg::REG_ALU: begin
               s_next.rdata[bla_pkg::ALU_BP_LSB +: 2] = s_reg.bp;
            end
            bla_pkg::REG_STAT: begin
               s_next.rdata[bla_pkg::STAT_CNT_LSB +: bla_pkg::CNT_W] = s_reg.trap_cnt;
            end
            bla_pkg::REG_PC: begin
               s_next.rdata = {s_reg.pc, bla_pkg::LOW_ALIGNED};
            end
            default: ;
         endcase
      end

      if (ext_req) begin
         s_next.ext_result = ex_if.ld_out;
         s_next.ext_valid  = 1'b1;
      end

      // A trap counted in the same cycle as a clear of the counter survives.
      unique case (s_reg.st)
         BLA_IDLE: begin
            if (acc_go && chk_if.trap) begin
               s_next.trap     = 1'b1;
               s_next.trap_cnt = s_next.trap_cnt + 16'h0001;
            end else if (acc_go) begin
               s_next.bus_req   = 1'b1;
               s_next.bus_addr  = acc_addr;
               s_next.bus_opt   = acc_opt;
               s_next.bus_space = acc_space;
               s_next.bus_instr = 1'b0;
               s_next.bus_wr    = !acc_load;
               s_next.bus_wdata = st_if.st_out;
               s_next.ld_lane   = acc_addr[1:0];
               s_next.ld_size   = acc_hw ? acc_size : bla_pkg::BLA_SZ_WORD;
               s_next.ld_sign   = acc_sign;
               // A signed hardware access aims the pointer at the low lane for word-only code.
               if (!s_reg.fz && acc_space != bla_pkg::BLA_SP_COP) begin
                  if (!s_reg.dw) begin
                     s_next.bp = acc_addr[1:0];
                  end else if (acc_sign) begin
                     s_next.bp = {2{~s_reg.bo}};
                  end
               end
               if (acc_load) begin
                  s_next.st = BLA_WAIT_DATA;
               end
            end else if (fetch_go) begin
               s_next.bus_req   = 1'b1;
               s_next.bus_addr  = {s_reg.pc, bla_pkg::LOW_ALIGNED};
               s_next.bus_opt   = bla_pkg::OPT_WORD;
               s_next.bus_space = bla_pkg::BLA_SP_MEM;
               s_next.bus_instr = 1'b1;
               s_next.bus_wr    = 1'b0;
               s_next.pc        = s_reg.pc + 30'h00000001;
               s_next.st        = BLA_WAIT_INS;
            end
         end
         BLA_WAIT_DATA: begin
            if (bus_rvalid) begin
               s_next.ld_data  = ld_if.ld_out;
               s_next.ld_valid = 1'b1;
               s_next.st       = BLA_IDLE;
            end
         end
         BLA_WAIT_INS: begin
            if (bus_rvalid) begin
               s_next.ins_word  = bus_rdata;
               s_next.ins_valid = 1'b1;
               s_next.st        = BLA_IDLE;
            end
         end
         default: s_next.st = BLA_IDLE;
      endcase

      // Target low bits are dropped, relying on the outside system to treat them as 00.
      if (jump_req) begin
         s_next.pc = jump_addr[31:2];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_reg <= RESET_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign acc_ready      = s_reg.st == BLA_IDLE;
   assign fetch_ready    = s_reg.st == BLA_IDLE && !acc_req;

   assign reg_rdata      = s_reg.rdata;
   assign ld_data        = s_reg.ld_data;
   assign ld_valid       = s_reg.ld_valid;
   assign ins_word       = s_reg.ins_word;
   assign ins_valid      = s_reg.ins_valid;

   assign bus_req        = s_reg.bus_req;
   assign bus_addr       = s_reg.bus_addr;
   assign bus_opt        = s_reg.bus_opt;
   assign bus_space      = s_reg.bus_space;
   assign bus_instr      = s_reg.bus_instr;
   assign bus_wr         = s_reg.bus_wr;
   assign bus_wdata      = s_reg.bus_wdata;
   assign ext_result     = s_reg.ext_result;
   assign ext_valid      = s_reg.ext_valid;
   assign trap_unaligned = s_reg.trap;
endmodule

// file: sim/bla_top_properties.sv
// Concurrent checks on the access, fetch and extract ports of the lane block.
// Assumes it is bound into bla_top and sees only that module's ports.
`timescale 1ns/10ps
module bla_top_properties (
   input wire logic                mclk,
   input wire logic                rstn,
   input wire logic                acc_req,
   input wire logic                acc_ready,
   input wire logic [31:0]         acc_addr,
   input wire logic [2:0]          acc_opt,
   input wire bla_pkg::bla_space_t acc_space,
   input wire logic                acc_load,
   input wire logic [31:0]         acc_src,
   input wire logic                fetch_req,
   input wire logic                fetch_ready,
   input wire logic                bus_req,
   input wire logic [31:0]         bus_addr,
   input wire logic [2:0]          bus_opt,
   input wire logic                bus_instr,
   input wire logic                bus_wr,
   input wire logic [31:0]         bus_wdata,
   input wire logic                bus_rvalid,
   input wire logic                ld_valid,
   input wire logic                ext_req,
   input wire logic                ext_valid,
   input wire logic                trap_unaligned
);
   logic take;
   logic bad;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // The trap enable is internal, so a misaligned access may legally pass without a trap.
   assign take = acc_req && acc_ready;
   assign bad  = acc_space == bla_pkg::BLA_SP_MEM
                 && ((acc_opt == bla_pkg::OPT_WORD && acc_addr[1:0] != 2'h0)
                 || (acc_opt == bla_pkg::OPT_HALF && acc_addr[0]));
   a_trap_cause: assert property (trap_unaligned |-> $past(take && bad))
      else $error("trap without a misaligned memory access");
   a_trap_quiet: assert property (trap_unaligned |-> !bus_req)
      else $error("trapped access started a bus transfer");
   a_safe_space: assert property (take && acc_space != bla_pkg::BLA_SP_MEM |=> !trap_unaligned)
      else $error("trap on a non-memory access");
   a_data_issue: assert property (take && !bad |=> bus_req && !bus_instr
      && bus_wr == !$past(acc_load)) else $error("data access not issued as data");
   a_opt_carry: assert property (take && !bad |=> bus_opt == $past(acc_opt)
      && bus_addr == $past(acc_addr)) else $error("option or address altered on bus");
   a_word_data: assert property (take && !bad && !acc_load
      && (acc_opt == bla_pkg::OPT_WORD || acc_space == bla_pkg::BLA_SP_COP)
      |=> bus_wdata == $past(acc_src)) else $error("store word altered");
   a_fetch_issue: assert property (fetch_req && fetch_ready |=> bus_req && bus_instr
      && bus_addr[1:0] == 2'h0) else $error("fetch not issued or unaligned");
   a_load_back: assert property (bus_rvalid && !bus_instr |=> ld_valid)
      else $error("load result missing");
   a_ext_answer: assert property (ext_req |=> ext_valid)
      else $error("extract result missing");
endmodule

bind bla_top bla_top_properties bla_top_properties_i (.mclk, .rstn, .acc_req, .acc_ready,
   .acc_addr, .acc_opt, .acc_space, .acc_load, .acc_src, .fetch_req, .fetch_ready, .bus_req,
   .bus_addr, .bus_opt, .bus_instr, .bus_wr, .bus_wdata, .bus_rvalid, .ld_valid, .ext_req,
   .ext_valid, .trap_unaligned);

// file: sim/bla_mem_model.sv
// Word-wide external memory with byte strobes on the far side of the lane block.
// Assumes one read at a time; slow stretches the answer, sys_bo is the system byte order.
`timescale 1ns/10ps
module bla_mem_model (
   input  wire logic        mclk,
   input  wire logic        slow,
   input  wire logic        sys_bo,
   input  wire logic        bus_req,
   input  wire logic [31:0] bus_addr,
   input  wire logic [2:0]  bus_opt,
   input  wire logic        bus_wr,
   input  wire logic [31:0] bus_wdata,
   output logic      [31:0] bus_rdata,
   output logic             bus_rvalid
);
   logic [31:0] mem [16];
   logic [31:0] last;
   int          cnt;
   logic        hit;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'h0;
      last = 32'h0;
      cnt = -1;
      bus_rdata = 32'h0;
      bus_rvalid = 1'b0;
   end
   // Address bits 1:0 never reach the array index, so reads take any target word aligned; byte and half-word writes use them to pick strobes.
   always @(posedge mclk) begin
      bus_rvalid <= cnt == 0;
      // Between answers the lines carry the inverse of the last word, never stale data.
      bus_rdata <= cnt == 0 ? last : ~last;
      if (cnt >= 0) cnt <= cnt - 1;
      if (bus_req && !bus_wr) begin
         last <= mem[bus_addr[5:2]];
         cnt <= slow ? 3 : 0;
      end
      if (bus_req && bus_wr)
         for (int i = 0; i < 4; i++) begin
            hit = bus_opt == 3'h1 ? i == (sys_bo ? bus_addr[1:0] : 2'h3 - bus_addr[1:0])
                : bus_opt != 3'h2 || i / 2 == (sys_bo ? bus_addr[1] : !bus_addr[1]);
            if (hit) mem[bus_addr[5:2]][8 * i +: 8] <= bus_wdata[8 * i +: 8];
         end
   end
endmodule

// file: sim/bla_top_tb.sv
// Self-checking bench for the lane block: register, access, fetch and extract paths.
// Assumes the memory model answers every bus read within a few cycles.
`timescale 1ns/10ps
module bla_top_tb;
   logic                mclk, rstn, reg_wr, reg_rd, acc_req, acc_ready, acc_load, acc_sign;
   logic [7:0]          reg_addr;
   logic [31:0]         reg_wdata, reg_rdata, acc_addr, acc_src, ld_data, jump_addr;
   logic [2:0]          acc_opt, bus_opt, o;
   bla_pkg::bla_space_t acc_space, bus_space;
   logic                ld_valid, fetch_req, fetch_ready, jump_req, ins_valid, bus_req;
   logic [31:0]         ins_word, bus_addr, bus_wdata, bus_rdata, ext_word, ext_result, got, x;
   logic                bus_instr, bus_wr, bus_rvalid, ext_req, ext_valid, trap_unaligned;
   bla_pkg::bla_ext_t   ext_op;
   logic                slow, sys_bo, br, tr, e;
   int                  miscompares, check_count, cycles;
   localparam logic [31:0] W = 32'h7F96A5C3;

   bla_top bla_top_i (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .acc_req, .acc_ready, .acc_addr, .acc_opt, .acc_space, .acc_load, .acc_sign, .acc_src,
      .ld_data, .ld_valid, .fetch_req, .fetch_ready, .jump_req, .jump_addr, .ins_word,
      .ins_valid, .bus_req, .bus_addr, .bus_opt, .bus_space, .bus_instr, .bus_wr, .bus_wdata,
      .bus_rdata, .bus_rvalid, .ext_req, .ext_op, .ext_word, .ext_result, .ext_valid,
      .trap_unaligned);
   bla_mem_model bla_mem_model_i (.mclk, .slow, .sys_bo, .bus_req, .bus_addr, .bus_opt,
      .bus_wr, .bus_wdata, .bus_rdata, .bus_rvalid);

   function automatic logic [31:0] sel(input logic [31:0] w, input logic [1:0] c,
                                       input logic b, input logic h, input logic s);
      logic [15:0] v;
      v = h ? w[16 * (b ? c[1] : !c[1]) +: 16] : {8'h00, w[8 * (b ? c : 2'h3 - c) +: 8]};
      if (h) return {{16{s & v[15]}}, v};
      return {{24{s & v[7]}}, v[7:0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      got = reg_rdata;
   endtask
   task automatic acc(input logic [31:0] a, input logic [2:0] op, input bla_pkg::bla_space_t sp,
                      input logic ld, input logic sg, input logic [31:0] s);
      int n;
      @(posedge mclk);
      acc_req <= 1'b1;
      acc_addr <= a;
      acc_opt <= op;
      acc_space <= sp;
      acc_load <= ld;
      acc_sign <= sg;
      acc_src <= s;
      @(posedge mclk);
      acc_req <= 1'b0;
      #1;
      br = bus_req;
      tr = trap_unaligned;
      n = 0;
      while (ld && br && ld_valid !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      got = ld_data;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // The ceiling is several times the length of the sequence below.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      {rstn, reg_wr, reg_rd, acc_req, acc_load, acc_sign, fetch_req, jump_req} = 8'h00;
      {reg_addr, reg_wdata, acc_addr, acc_src, jump_addr, ext_word, acc_opt} = '0;
      {ext_req, slow, sys_bo} = 3'h0;
      acc_space = bla_pkg::BLA_SP_MEM;
      ext_op = bla_pkg::BLA_EX_BYTE;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      rd(bla_pkg::REG_CFG);
      chk("cfg_reset", got, 32'h0);
      rd(8'h14);
      chk("unmapped", got, 32'h0);
      acc(32'h20, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, W);
      for (int k = 3; k >= 0; k--) begin
         acc(32'h20 + k, bla_pkg::OPT_BYTE, bla_pkg::BLA_SP_MEM, 1'b1, 1'b1, 32'h0);
         chk("sw_load", got, W);
         rd(bla_pkg::REG_ALU);
         chk("pointer", got, k);
      end
      wr(bla_pkg::REG_CPS, 32'h2);
      acc(32'h21, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_MEM, 1'b1, 1'b0, 32'h0);
      wr(bla_pkg::REG_CPS, 32'h0);
      acc(32'h23, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_COP, 1'b1, 1'b0, 32'h0);
      rd(bla_pkg::REG_ALU);
      chk("pointer_kept", got, 32'h0);
      for (int b = 0; b < 2; b++) begin
         wr(bla_pkg::REG_CFG, b);
         for (int op = 0; op < 3; op++) begin
            ext(bla_pkg::bla_ext_t'(op), W);
            chk("extract", got, sel(W, 2'h0, b, op != 0, op == 2));
         end
      end
      for (int b = 0; b < 2; b++) begin
         wr(bla_pkg::REG_CFG, 32'h2 | b);
         sys_bo <= b;
         for (int k = 0; k < 16; k++) begin
            slow <= k[0];
            o = k[2] ? bla_pkg::OPT_HALF : bla_pkg::OPT_BYTE;
            acc(32'h20 + k[4:3] * 0 + (k >> 3) * 2 + k[1], o, bla_pkg::BLA_SP_MEM, 1'b1, k[0], 0);
            x = sel(W, 2'((k >> 3) * 2 + k[1]), b, k[2], k[0]);
            chk("hw_load", got, x);
         end
         ext(bla_pkg::BLA_EX_BYTE, W);
         chk("hw_pointer", got, {24'h0, W[7:0]});
         chk("data_kind", bus_instr, 1'b0);
         acc(32'h21, bla_pkg::OPT_BYTE, bla_pkg::BLA_SP_COP, 1'b1, 1'b1, 32'h0);
         chk("cop_load", got, W);
         acc(32'h21, bla_pkg::OPT_BYTE, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, 32'h1234565A);
         chk("byte_repl", bus_wdata, 32'h5A5A5A5A);
         acc(32'h20, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_MEM, 1'b1, 1'b0, 32'h0);
         x = W;
         x[8 * (b ? 1 : 2) +: 8] = 8'h5A;
         chk("byte_write", got, x);
         acc(32'h22, bla_pkg::OPT_HALF, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, 32'hBEEF1234);
         chk("half_repl", bus_wdata, 32'h12341234);
         acc(32'h20, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, W);
      end
      acc(32'h20, 3'h4, bla_pkg::BLA_SP_ROM, 1'b1, 1'b0, 32'h0);
      chk("rom_load", br, 1'b1);
      chk("rom_space", bus_space, bla_pkg::BLA_SP_ROM);
      acc(32'h20, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_ROM, 1'b0, 1'b0, W);
      chk("rom_store", br, 1'b1);
      wr(bla_pkg::REG_CPS, 32'h1);
      for (int k = 0; k < 12; k++) begin
         o = k < 4 ? bla_pkg::OPT_WORD : k < 8 ? bla_pkg::OPT_HALF : bla_pkg::OPT_BYTE;
         e = (k < 4 && k % 4 != 0) || (k >= 4 && k < 8 && k % 2 == 1);
         acc(32'h40 + k % 4, o, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, W);
         chk("trap", tr, e);
         chk("trap_bus", br, !e);
      end
      acc(32'h41, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_IO, 1'b0, 1'b0, W);
      chk("io_trap", tr, 1'b0);
      acc(32'h41, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_COP, 1'b0, 1'b0, W);
      chk("cop_trap", tr, 1'b0);
      wr(bla_pkg::REG_CPS, 32'h0);
      acc(32'h41, bla_pkg::OPT_WORD, bla_pkg::BLA_SP_MEM, 1'b0, 1'b0, W);
      chk("off_trap", tr, 1'b0);
      rd(bla_pkg::REG_STAT);
      chk("trap_count", got, 32'h5);
      @(posedge mclk);
      jump_req <= 1'b1;
      jump_addr <= 32'h103;
      @(posedge mclk);
      jump_req <= 1'b0;
      fetch_req <= 1'b1;
      @(posedge mclk);
      fetch_req <= 1'b0;
      #1;
      chk("fetch_addr", bus_addr, 32'h100);
      chk("fetch_kind", bus_instr, 1'b1);
      repeat (6) @(posedge mclk);
      rd(bla_pkg::REG_PC);
      chk("pc", got, 32'h104);
      chk("fetch_word", ins_word, W);
      stop_test();
   end

   task automatic ext(input bla_pkg::bla_ext_t op, input logic [31:0] w);
      @(posedge mclk);
      ext_req <= 1'b1;
      ext_op <= op;
      ext_word <= w;
      @(posedge mclk);
      ext_req <= 1'b0;
      #1;
      got = ext_result;
   endtask
endmodule
